// ==== cmc_pkg.sv ====
// Shared constants, types and helpers for the dual comparator control block.
// Assumes a 12-bit APB byte address; each register sits on an aligned word.
package cmc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'h01f; // Comparator control
  localparam logic [11:0] IDX_IRQC = 12'h00b; // Irq control (global, peripheral enables)
  localparam logic [11:0] IDX_PFLG = 12'h00c; // Peripheral flag
  localparam logic [11:0] IDX_PENA = 12'h08c; // Peripheral enable
  localparam logic [11:0] IDX_DIR  = 12'h085; // Port A direction
  localparam logic [11:0] IDX_DATA = 12'h005; // Port A data

  // Field positions
  localparam int CTRL_R2_BIT  = 7; // Second result bit
  localparam int CTRL_R1_BIT  = 6; // First result bit
  localparam int CTRL_CIS_BIT = 3; // Input switch bit
  localparam int FLAG_BIT     = 6; // Change flag
  localparam int CHG_EN_BIT   = 6; // Change irq enable
  localparam int GIE_BIT      = 7; // Global irq enable
  localparam int PERIPHERAL_IRQ_ENABLE_BIT     = 6; // Peripheral irq enable

  // Values after reset
  localparam logic [2:0] MODE_RST = 3'h0;  // Comparator reset mode
  localparam logic       CIS_RST  = 1'h0;  // Input switch
  localparam logic [4:0] DIR_RST  = 5'h1f; // All pins input
  localparam logic [4:0] DATA_RST = 5'h00; // Port data latch

  // Synchroniser depth for the raw comparator results
  localparam int SYNC_STAGES = 2;

  // Routing modes, encoded as the mode field
  typedef enum logic [2:0] {
    MODE_RESET   = 3'h0, // All comparator pins analog, comparators down
    MODE_MUX3    = 3'h1, // Three inputs, switch picks first inverting input
    MODE_VREF    = 3'h2, // Internal reference on both non-inverting inputs
    MODE_COMMON  = 3'h3, // Two comparators, common reference
    MODE_INDEP2  = 3'h4, // Two independent comparators
    MODE_INDEP1  = 3'h5, // One independent comparator
    MODE_OUTPUTS = 3'h6, // Common reference, results on pins a3/a4
    MODE_OFF     = 3'h7  // Both comparators off
  } cmc_mode_e;

  // APB request group from the master
  typedef struct packed {
    logic        psel;    // Slave select
    logic        penable; // Access phase
    logic        pwrite;  // Direction
    logic [11:0] paddr;   // Byte address
    logic [31:0] pwdata;  // Write data
  } cmc_apb_req_s;

  // Analog front-end steering
  typedef struct packed {
    logic       c1_pwr;       // First comparator powered
    logic       c2_pwr;       // Second comparator powered
    logic       vref_vplus;   // Internal reference on non-inverting inputs
    logic       c1_vminus_a3; // First inverting input from pin a3, else a0
    logic [4:0] analog_pins;  // Pins held as analog inputs
  } cmc_ana_s;

  // Byte address of a register index
  function automatic logic [11:0] addr_of(input logic [11:0] idx);
    addr_of = {idx[9:0], 2'b00};
  endfunction

  // Pins configured as analog inputs in each mode
  function automatic logic [4:0] analog_mask(input cmc_mode_e m);
    unique case (m)
      MODE_RESET:   analog_mask = 5'h0f;
      MODE_MUX3:    analog_mask = 5'h0f;
      MODE_VREF:    analog_mask = 5'h0f;
      MODE_COMMON:  analog_mask = 5'h07;
      MODE_INDEP2:  analog_mask = 5'h0f;
      MODE_INDEP1:  analog_mask = 5'h06;
      MODE_OUTPUTS: analog_mask = 5'h07;
      MODE_OFF:     analog_mask = 5'h00;
    endcase
  endfunction

endpackage

// ==== cmc_sync.sv ====
// Two-flop style synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; multi-bit coherence is not promised.
`timescale 1ns/100ps
`default_nettype none
module cmc_sync #(
  parameter int W      = 2, // Bundle width
  parameter int STAGES = 2  // Flop stages, at least two
) (
  input  wire logic         clk,     // Destination clock
  input  wire logic         rst_n,   // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous levels
  output logic      [W-1:0] q        // Synchronised levels
);

  logic [W-1:0] chain_r [STAGES]; // Stage 0 is read only by stage 1

  // Shift chain; only the last stage leaves the module
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_r[i] <= '0;
      end
    end else begin
      chain_r[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        chain_r[i] <= chain_r[i-1];
      end
    end
  end

  assign q = chain_r[STAGES-1];

endmodule // cmc_sync
`default_nettype wire

// ==== cmc_top.sv ====
// Digital control of a dual analog comparator unit with APB registers.
// Assumes raw results come from analog comparators, asynchronous to pclk;
// pin inputs and sleep request are synchronous to pclk.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module cmc_top (
  input  wire logic                  pclk,       // 100 MHz clock
  input  wire logic                  presetn,    // Async reset, active low
  input  wire cmc_pkg::cmc_apb_req_s apb_req,    // APB request group
  output logic                       pready,     // APB ready
  output logic [31:0]                prdata,     // APB read data
  output logic                       pslverr,    // APB error, unmapped address
  input  wire logic [1:0]            cmp_raw,    // Raw results, bit0 first, bit1 second
  input  wire logic [4:0]            pin_in,     // Port A pin levels
  input  wire logic                  sleep_mode, // Core is asleep
  output logic [4:0]                 port_out,   // Port A pin drive values
  output logic [4:0]                 port_oe_n,  // Port A drive enables, low drives
  output cmc_pkg::cmc_ana_s          ana,        // Analog steering
  output logic                       irq_req,    // Interrupt request to core
  output logic                       wake_req    // Wake request while asleep
);

  // Control state
  cmc_pkg::cmc_mode_e mode_r;   // Routing mode field
  logic               cis_r;    // Input switch bit
  logic [1:0]         ref_r;    // Latched reference results
  logic               flag_r;   // Change flag
  logic               chg_en_r; // Change irq enable
  logic               gie_r;    // Global irq enable
  logic               peripheral_irq_enable_r;   // Peripheral irq enable
  logic [4:0]         dir_r;    // Port direction, 1 is input
  logic [4:0]         data_r;   // Port data latch
  logic [1:0]         cmp_sync; // Synchronised results
  logic [31:0]        rd_nxt;   // Read data for the coming access
  logic               map_nxt;  // Address maps to a register
  logic               setup;    // APB setup cycle
  logic               done;     // APB access completes this edge
  logic               wr;       // Completing write
  logic               mismatch; // Results differ from reference

  // Results cross into pclk before any compare
  cmc_sync #(
    .W      (2),
    .STAGES (cmc_pkg::SYNC_STAGES)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (cmp_raw),
    .q     (cmp_sync)
  );

  // Bus phase decode
  assign setup    = apb_req.psel && !apb_req.penable;
  assign done     = apb_req.psel && apb_req.penable && pready;
  assign wr       = done && apb_req.pwrite;
  assign mismatch = (cmp_sync != ref_r);

  // Read mux and address decode
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    map_nxt = 1'b1;
    unique case (apb_req.paddr)
      cmc_pkg::addr_of(cmc_pkg::IDX_CTRL): begin
        // Results come from the synchroniser, never from stored writes
        rd_nxt[cmc_pkg::CTRL_R2_BIT]  = cmp_sync[1];
        rd_nxt[cmc_pkg::CTRL_R1_BIT]  = cmp_sync[0];
        rd_nxt[cmc_pkg::CTRL_CIS_BIT] = cis_r;
        rd_nxt[2:0]                   = mode_r;
      end
      cmc_pkg::addr_of(cmc_pkg::IDX_IRQC): begin
        rd_nxt[cmc_pkg::GIE_BIT]  = gie_r;
        rd_nxt[cmc_pkg::PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_r;
      end
      cmc_pkg::addr_of(cmc_pkg::IDX_PFLG): begin
        rd_nxt[cmc_pkg::FLAG_BIT] = flag_r;
      end
      cmc_pkg::addr_of(cmc_pkg::IDX_PENA): begin
        rd_nxt[cmc_pkg::CHG_EN_BIT] = chg_en_r;
      end
      cmc_pkg::addr_of(cmc_pkg::IDX_DIR): begin
        rd_nxt[4:0] = dir_r;
      end
      cmc_pkg::addr_of(cmc_pkg::IDX_DATA): begin
        // Analog pins read low whatever the pin level
        rd_nxt[4:0] = pin_in & ~cmc_pkg::analog_mask(mode_r);
      end
      default: begin
        map_nxt = 1'b0; // Unmapped: zero data, error
      end
    endcase
  end

  // APB answer: one cycle after setup, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !map_nxt;
      if (setup) begin
        prdata <= rd_nxt;
      end
    end
  end

  // Control register: mode and switch; only reset or a write touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= cmc_pkg::cmc_mode_e'(cmc_pkg::MODE_RST);
      cis_r  <= cmc_pkg::CIS_RST;
    end else if (wr && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_CTRL)) begin
      // Result bits in the write data are dropped
      mode_r <= cmc_pkg::cmc_mode_e'(apb_req.pwdata[2:0]);
      cis_r  <= apb_req.pwdata[cmc_pkg::CTRL_CIS_BIT];
    end
  end
  // Sleep is deliberately absent above: waking leaves the register intact

  // Reference results: any control access ends the mismatch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= 2'h0;
    end else if (done && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_CTRL)) begin
      ref_r <= cmp_sync;
    end
  end

  // Change flag; a hardware set beats a software clear in the same cycle,
  // so a change that meets a control read is never missed here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (mismatch) begin
      flag_r <= 1'b1;
    end else if (wr && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_PFLG)) begin
      flag_r <= apb_req.pwdata[cmc_pkg::FLAG_BIT];
    end
  end

  // Interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_en_r <= 1'b0;
      gie_r    <= 1'b0;
      peripheral_irq_enable_r   <= 1'b0;
    end else if (wr) begin
      if (apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_PENA)) begin
        chg_en_r <= apb_req.pwdata[cmc_pkg::CHG_EN_BIT];
      end
      if (apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_IRQC)) begin
        gie_r  <= apb_req.pwdata[cmc_pkg::GIE_BIT];
        peripheral_irq_enable_r <= apb_req.pwdata[cmc_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
      end
    end
  end

  // Port direction and data latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r  <= cmc_pkg::DIR_RST;
      data_r <= cmc_pkg::DATA_RST;
    end else if (wr) begin
      if (apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_DIR)) begin
        dir_r <= apb_req.pwdata[4:0];
      end
      if (apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_DATA)) begin
        data_r <= apb_req.pwdata[4:0];
      end
    end
  end

  // Pin drivers; direction bits stay the enables in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out  <= 5'h00;
      port_oe_n <= 5'h1f;
    end else begin
      port_oe_n <= dir_r;
      port_out  <= data_r;
      if (mode_r == cmc_pkg::MODE_OUTPUTS) begin
        // Raw results skip the synchroniser; a glitch reaches the pin
        port_out[3] <= cmp_raw[0];
        port_out[4] <= cmp_raw[1];
      end
    end
  end

  // Analog steering; reset holds both comparators down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana.c1_pwr       <= 1'b0;
      ana.c2_pwr       <= 1'b0;
      ana.vref_vplus   <= 1'b0;
      ana.c1_vminus_a3 <= 1'b0;
      ana.analog_pins  <= 5'h0f;
    end else begin
      ana.c1_pwr       <= !(mode_r inside {cmc_pkg::MODE_RESET, cmc_pkg::MODE_INDEP1,
                                           cmc_pkg::MODE_OFF});
      ana.c2_pwr       <= !(mode_r inside {cmc_pkg::MODE_RESET, cmc_pkg::MODE_OFF});
      ana.vref_vplus   <= (mode_r == cmc_pkg::MODE_VREF);
      ana.c1_vminus_a3 <= (mode_r == cmc_pkg::MODE_MUX3) && cis_r;
      ana.analog_pins  <= cmc_pkg::analog_mask(mode_r);
    end
  end

  // Interrupt and wake; comparators keep running in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req  <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq_req  <= flag_r && chg_en_r && peripheral_irq_enable_r && gie_r;
      wake_req <= sleep_mode && flag_r && chg_en_r;
    end
  end

  // Helper: no control write seen since reset
  logic ctrl_fresh_r; // Mode must still be the reset mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_fresh_r <= 1'b1;
    end else if (wr && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_CTRL)) begin
      ctrl_fresh_r <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Steps of a register access
  sequence setup_at(logic [11:0] a);
    apb_req.psel && !apb_req.penable && apb_req.paddr == a;
  endsequence
  sequence read_done;
    apb_req.psel && apb_req.penable && !apb_req.pwrite && pready;
  endsequence

  reset_mode_a: assert property (ctrl_fresh_r |-> mode_r == cmc_pkg::MODE_RESET)
    else $error("mode left reset value without a write");

  reset_power_a: assert property (ctrl_fresh_r |=> !ana.c1_pwr && !ana.c2_pwr)
    else $error("comparator powered in reset mode");

  flag_set_a: assert property (mismatch |=> flag_r)
    else $error("mismatch did not set change flag");

  flag_hold_a: assert property (mismatch && wr |=> flag_r ##1 flag_r || !mismatch)
    else $error("flag cleared while mismatch persisted");

  flag_write_a: assert property (wr && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_PFLG)
      && !mismatch |=> flag_r == $past(apb_req.pwdata[cmc_pkg::FLAG_BIT]))
    else $error("flag write not honoured");

  ref_latch_a: assert property (done && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_CTRL)
      |=> ref_r == $past(cmp_sync))
    else $error("control access did not relatch results");

  result_read_a: assert property (setup_at(cmc_pkg::addr_of(cmc_pkg::IDX_CTRL)) ##1 read_done
      |-> prdata[7:6] == $past(cmp_sync) && prdata[5:4] == 2'h0)
    else $error("control read shows wrong result bits");

  port_read_a: assert property (setup_at(cmc_pkg::addr_of(cmc_pkg::IDX_DATA)) ##1 read_done
      |-> (prdata[4:0] & $past(cmc_pkg::analog_mask(mode_r))) == 5'h00)
    else $error("analog pin read nonzero");

  irq_gate_a: assert property (!(gie_r && peripheral_irq_enable_r && chg_en_r) |=> !irq_req)
    else $error("interrupt raised while disabled");

  irq_raise_a: assert property (flag_r && gie_r && peripheral_irq_enable_r && chg_en_r |=> irq_req)
    else $error("enabled flag raised no interrupt");

  pin_mux_a: assert property (mode_r == cmc_pkg::MODE_OUTPUTS
      |=> port_out[4:3] == $past(cmp_raw))
    else $error("results not on pins a3 a4");

  pin_enable_a: assert property (1'b1 |=> port_oe_n == $past(dir_r))
    else $error("pin enable differs from direction");

  off_mode_a: assert property (mode_r == cmc_pkg::MODE_OFF [*2]
      |-> !ana.c1_pwr && !ana.c2_pwr)
    else $error("comparators powered in off mode");

  vref_route_a: assert property (mode_r == cmc_pkg::MODE_VREF |=> ana.vref_vplus)
    else $error("internal reference not routed");

  switch_route_a: assert property (mode_r == cmc_pkg::MODE_MUX3
      |=> ana.c1_vminus_a3 == $past(cis_r))
    else $error("input switch routing wrong");

  wake_path_a: assert property (sleep_mode && flag_r && chg_en_r |=> wake_req)
    else $error("enabled change did not wake");

  // Control write loads mode and switch from the low byte
  ctrl_load_a: assert property (
      wr && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_CTRL)
      |=> mode_r == $past(apb_req.pwdata[2:0])
      && cis_r == $past(apb_req.pwdata[cmc_pkg::CTRL_CIS_BIT]))
    else $error("control write not loaded");

  // Without a control write the register holds, asleep or awake
  mode_keep_a: assert property (
      !(wr && apb_req.paddr == cmc_pkg::addr_of(cmc_pkg::IDX_CTRL))
      |=> mode_r == $past(mode_r) && cis_r == $past(cis_r))
    else $error("control register changed without a write");

  // Outside the output mode every pin carries the data latch
  pin_latch_a: assert property (
      mode_r != cmc_pkg::MODE_OUTPUTS |=> port_out == $past(data_r))
    else $error("pin drive differs from data latch");

  // Single-comparator mode powers only the second comparator
  indep1_power_a: assert property (
      mode_r == cmc_pkg::MODE_INDEP1 |=> !ana.c1_pwr && ana.c2_pwr)
    else $error("wrong power in single comparator mode");

  // Reset mode holds the four comparator pins analog
  reset_analog_a: assert property (
      mode_r == cmc_pkg::MODE_RESET |=> ana.analog_pins == 5'h0f)
    else $error("reset mode left a pin digital");

  // Switch routing only acts in the three-input mode
  switch_idle_a: assert property (
      mode_r != cmc_pkg::MODE_MUX3 |=> !ana.c1_vminus_a3)
    else $error("input switch routed outside its mode");

  // No wake request while the core runs
  awake_quiet_a: assert property (!sleep_mode |=> !wake_req)
    else $error("wake request while awake");

endmodule // cmc_top
`default_nettype wire

// ==== cmc_far_model.sv ====
// Far-side model: analog comparator outputs and port A pin levels.
// Assumes the bench sets wanted results and outside pin levels.
`timescale 1ns/100ps
`default_nettype none
module cmc_far_model (
  input  wire logic       pclk,      // Core clock
  input  wire logic [1:0] res_set,   // Wanted comparator results
  input  wire logic [4:0] ext_lvl,   // Levels applied from outside
  input  wire logic [4:0] port_out,  // Design pin drive values
  input  wire logic [4:0] port_oe_n, // Design drive enables, low drives
  output logic      [1:0] cmp_raw,   // Comparator outputs
  output logic      [4:0] pin_in     // Resolved pin levels
);
  // One process owns both outputs: known levels first, then clocked updates
  initial begin
    cmp_raw = 2'h0;
    pin_in  = 5'h00;
    forever begin
      @(posedge pclk);
      // Output high when plus exceeds minus; launched on the clock to avoid races
      cmp_raw <= res_set;
      // Driven pins show the design value, released pins the outside level
      pin_in <= (port_out & ~port_oe_n) | (ext_lvl & port_oe_n);
    end
  end
endmodule // cmc_far_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the comparator control block over APB.
// Assumes zero-wait APB answers and one-edge output registering.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                  pclk       = 1'b0;  // Core clock
  logic                  presetn    = 1'b0;  // Reset, active low
  logic                  sleep_mode = 1'b0;  // Core asleep
  cmc_pkg::cmc_apb_req_s apb_req    = '0;    // APB request group
  logic [1:0]            res_set    = 2'h0;  // Wanted results
  logic [4:0]            ext_lvl    = 5'h1f; // Outside pin levels
  logic                  pready, pslverr, irq_req, wake_req;
  logic [31:0]           prdata;
  logic [1:0]            cmp_raw;
  logic [4:0]            pin_in, port_out, port_oe_n;
  cmc_pkg::cmc_ana_s     ana;
  int                    err_total  = 0;     // Mismatches
  int                    n_compared = 0;     // Comparisons made
  logic [31:0]           rdv;                // Read scratch
  logic                  sev;                // Error scratch
  logic [7:0]            c1_map     = 8'h5e; // Modes powering first comparator
  logic [7:0]            c2_map     = 8'h7e; // Modes powering second comparator
  logic [4:0]            msk [8]    = '{5'h0f, 5'h0f, 5'h0f, 5'h07, 5'h0f, 5'h06, 5'h07, 5'h00};

  // 100 MHz clock
  always #5 pclk = ~pclk;

  cmc_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmp_raw(cmp_raw), .pin_in(pin_in),
    .sleep_mode(sleep_mode), .port_out(port_out), .port_oe_n(port_oe_n), .ana(ana),
    .irq_req(irq_req), .wake_req(wake_req));

  cmc_far_model u_far (.pclk(pclk), .res_set(res_set), .ext_lvl(ext_lvl),
    .port_out(port_out), .port_oe_n(port_oe_n), .cmp_raw(cmp_raw), .pin_in(pin_in));

  // Verdict and end of run
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Word compare
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // Single flag compare
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", nm, exp, got);
      err_total++;
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic serr);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx[9:0], 2'b00}, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      // Hung slave
      err_total++;
      finish_test();
    end
    rdat = prdata;
    serr = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // Register write
  task automatic reg_wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  // Register read and compare
  task automatic reg_chk(input logic [11:0] idx, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk_word(nm, exp, r);
  endtask

  // Let registered outputs land
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Main sequence
  initial begin
    settle(10);
    chk_word("ana in reset", 32'h0000000f, {23'h0, ana});
    chk_word("oe in reset", 32'h0000001f, {27'h0, port_oe_n});
    @(posedge pclk);
    presetn <= 1'b1;
    settle(4);
    reg_chk(cmc_pkg::IDX_CTRL, 32'h0, "control");
    reg_chk(cmc_pkg::IDX_DIR, 32'h1f, "direction");
    reg_chk(cmc_pkg::IDX_PFLG, 32'h0, "flag");
    // Unmapped place answers with an error and no data
    apb(1'b0, 12'h0ff, 32'h0, rdv, sev);
    chk_bit("slverr", 1'b1, sev);
    chk_word("unmapped data", 32'h0, rdv);
    // Every mode, with read-only bits written as ones; change irq stays off
    for (int m = 0; m < 8; m++) begin
      reg_wr(cmc_pkg::IDX_CTRL, 32'hf8 | 32'(m));
      settle(2);
      rdv = {23'h0, c1_map[m], c2_map[m], m == 2, m == 1, msk[m]};
      chk_word("steer", rdv, {23'h0, ana});
      reg_chk(cmc_pkg::IDX_CTRL, {24'h0, 5'h01, m[2:0]}, "control bits");
    end
    // Three-input mode with the switch low takes the other pin
    reg_wr(cmc_pkg::IDX_CTRL, 32'h01);
    settle(2);
    chk_bit("switch low", 1'b0, ana.c1_vminus_a3);
    // Result change sets the flag and a mismatch keeps it set
    reg_wr(cmc_pkg::IDX_CTRL, 32'h03);
    @(posedge pclk);
    res_set <= 2'h3;
    settle(6);
    reg_chk(cmc_pkg::IDX_PFLG, 32'h40, "flag set");
    reg_wr(cmc_pkg::IDX_PFLG, 32'h0);
    reg_chk(cmc_pkg::IDX_PFLG, 32'h40, "flag kept");
    reg_chk(cmc_pkg::IDX_CTRL, 32'hc3, "results");
    reg_wr(cmc_pkg::IDX_PFLG, 32'h0);
    reg_chk(cmc_pkg::IDX_PFLG, 32'h0, "flag cleared");
    reg_wr(cmc_pkg::IDX_PFLG, 32'h40);
    reg_chk(cmc_pkg::IDX_PFLG, 32'h40, "flag by write");
    // Enables one by one; only all three raise the request
    reg_wr(cmc_pkg::IDX_PENA, 32'h40);
    settle(2);
    chk_bit("irq one enable", 1'b0, irq_req);
    reg_wr(cmc_pkg::IDX_IRQC, 32'h40);
    settle(2);
    chk_bit("irq two enables", 1'b0, irq_req);
    reg_wr(cmc_pkg::IDX_IRQC, 32'hc0);
    settle(2);
    chk_bit("irq all enables", 1'b1, irq_req);
    // Sleep: comparators run on and a change wakes
    @(posedge pclk);
    sleep_mode <= 1'b1;
    reg_wr(cmc_pkg::IDX_PFLG, 32'h0);
    settle(2);
    chk_bit("no wake", 1'b0, wake_req);
    @(posedge pclk);
    res_set <= 2'h2;
    settle(6);
    chk_bit("wake", 1'b1, wake_req);
    @(posedge pclk);
    sleep_mode <= 1'b0;
    reg_chk(cmc_pkg::IDX_CTRL, 32'h83, "control after wake");
    // Results on pins a3/a4; irq off before the mode change
    reg_wr(cmc_pkg::IDX_PENA, 32'h0);
    reg_wr(cmc_pkg::IDX_DIR, 32'h07);
    reg_wr(cmc_pkg::IDX_DATA, 32'h0);
    reg_wr(cmc_pkg::IDX_CTRL, 32'h06);
    @(posedge pclk);
    res_set <= 2'h1;
    settle(4);
    chk_word("pin results", 32'h1, {30'h0, port_out[4:3]});
    chk_word("pin enables", 32'h07, {27'h0, port_oe_n});
    reg_chk(cmc_pkg::IDX_DATA, 32'h08, "port read");
    // Other pins still follow the data latch in the output mode
    reg_wr(cmc_pkg::IDX_DATA, 32'h15);
    settle(2);
    chk_word("pin latch", 32'h0d, {27'h0, port_out});
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    settle(2);
    chk_word("ana mid reset", 32'h0000000f, {23'h0, ana});
    @(posedge pclk);
    presetn <= 1'b1;
    settle(4);
    reg_chk(cmc_pkg::IDX_CTRL, 32'h40, "control after reset");
    reg_chk(cmc_pkg::IDX_DIR, 32'h1f, "direction after reset");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
